// >>> logic/electrode_fault_pkg.sv
// package: offsets, field positions and carrier types of the electrode fault status block
`default_nettype none
package electrode_fault_pkg;
  localparam logic [7:0] CONN_STATUS_ADDR = 8'h1d;
  localparam logic [7:0] DC_FLAGS_ADDR = 8'h1e;
  localparam int REG_W = 24;
  localparam logic [23:0] CONN_STATUS_RESET = 24'h000000;
  localparam logic [23:0] DC_FLAGS_RESET = 24'h000000;
  // connection status word fields
  localparam int CONN_RLD_BIT = 23;
  localparam int CONN_LA_BIT = 22;
  localparam int CONN_LL_BIT = 21;
  localparam int CONN_RA_BIT = 20;
  localparam int CONN_CE_BIT = 13;
  localparam int COR_LA_BIT = 12;
  localparam int COR_LL_BIT = 11;
  localparam int COR_RA_BIT = 10;
  // dc range flag fields
  localparam int OVR_RLD_BIT = 23;
  localparam int OVR_LA_BIT = 22;
  localparam int OVR_LL_BIT = 21;
  localparam int OVR_RA_BIT = 20;
  localparam int OVR_CE_BIT = 13;
  localparam int UND_RLD_BIT = 12;
  localparam int UND_LA_BIT = 11;
  localparam int UND_LL_BIT = 10;
  localparam int UND_RA_BIT = 9;
  localparam int UND_CE_BIT = 2;
  // per-electrode fault vector: order rld, la, ll, ra, ce
  typedef struct packed {
    logic right_leg_drive_electrode;
    logic la;
    logic ll;
    logic ra;
    logic ce;
  } electrode_vec_type;
  // per-channel converter out-of-range: la, ll, ra
  typedef struct packed {
    logic la;
    logic ll;
    logic ra;
  } channel_vec_type;
  // register read command from the serial port
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } read_cmd_type;
endpackage : electrode_fault_pkg
`default_nettype wire

// >>> logic/electrode_fault_status.sv
// electrode connection status and dc range flag registers
// Operation
// - single enabled method drives connection status bits
// - both enabled: limb status bits 23..20 carry only ac
// - dc register holds comparator range flags, not dc_fault_i
// - common electrode status from dc only
// - status bits 23,22,21,20,13; 1=disconnected
// - conversion out-of-range flags bits 12,11,10
// - sticky OR, cleared on frame buffer load
// - overrange flags at 23..20,13 above 2.4V
// - underrange flags at 12..9,2 below 0.2V
// - dc flags straight from comparators
// - dc register read only by command
// - status register at 0x1d, resets zero
`timescale 1ns/1ps
`default_nettype none
module electrode_fault_status
  import electrode_fault_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic dc_detect_en_i,
  input wire logic ac_detect_en_i,
  input wire electrode_vec_type dc_fault_i,
  input wire electrode_vec_type ac_fault_i,
  input wire channel_vec_type conv_out_of_range_i,
  input wire electrode_vec_type overrange_cmp_i,
  input wire electrode_vec_type underrange_cmp_i,
  input wire logic frame_load_i,
  input wire read_cmd_type read_cmd_i,
  input wire logic write_cmd_i,
  output logic [REG_W-1:0] frame_status_o,
  output logic [REG_W-1:0] read_data_o,
  output logic read_valid_o
);

  // pack an electrode vector and converter flags into the connection word
  function automatic logic [REG_W-1:0] pack_conn(input electrode_vec_type e, input channel_vec_type c);
    logic [REG_W-1:0] w;
    w = '0;
    w[CONN_RLD_BIT] = e.right_leg_drive_electrode;
    w[CONN_LA_BIT] = e.la;
    w[CONN_LL_BIT] = e.ll;
    w[CONN_RA_BIT] = e.ra;
    w[CONN_CE_BIT] = e.ce;
    w[COR_LA_BIT] = c.la;
    w[COR_LL_BIT] = c.ll;
    w[COR_RA_BIT] = c.ra;
    return w;
  endfunction : pack_conn

  // pack over and under comparator vectors into the dc word
  function automatic logic [REG_W-1:0] pack_dc(input electrode_vec_type o, input electrode_vec_type u);
    logic [REG_W-1:0] w;
    w = '0;
    w[OVR_RLD_BIT] = o.right_leg_drive_electrode;
    w[OVR_LA_BIT] = o.la;
    w[OVR_LL_BIT] = o.ll;
    w[OVR_RA_BIT] = o.ra;
    w[OVR_CE_BIT] = o.ce;
    w[UND_RLD_BIT] = u.right_leg_drive_electrode;
    w[UND_LA_BIT] = u.la;
    w[UND_LL_BIT] = u.ll;
    w[UND_RA_BIT] = u.ra;
    w[UND_CE_BIT] = u.ce;
    return w;
  endfunction : pack_dc

  logic [REG_W-1:0] conn_reg;
  logic [REG_W-1:0] conn_next;
  logic [REG_W-1:0] dc_reg;
  logic [REG_W-1:0] read_data_reg;
  logic read_valid_reg;
  logic [REG_W-1:0] frame_reg;
  electrode_vec_type sel_fault;
  logic [REG_W-1:0] conn_event;
  logic [REG_W-1:0] read_mux;
  logic hit_conn;
  logic hit_dc;

  // method selection: ac wins when both run; the common electrode is dc only
  assign sel_fault.right_leg_drive_electrode = ac_detect_en_i ? ac_fault_i.right_leg_drive_electrode : (dc_detect_en_i & dc_fault_i.right_leg_drive_electrode);
  assign sel_fault.la = ac_detect_en_i ? ac_fault_i.la : (dc_detect_en_i & dc_fault_i.la);
  assign sel_fault.ll = ac_detect_en_i ? ac_fault_i.ll : (dc_detect_en_i & dc_fault_i.ll);
  assign sel_fault.ra = ac_detect_en_i ? ac_fault_i.ra : (dc_detect_en_i & dc_fault_i.ra);
  assign sel_fault.ce = dc_detect_en_i & dc_fault_i.ce;
  assign conn_event = pack_conn(sel_fault, conv_out_of_range_i);

  // sticky accumulation; a fault in the load cycle starts the next frame, so none is lost
  assign conn_next = frame_load_i ? conn_event : (conn_reg | conn_event);

  // register read decode; write commands have no path into either register
  assign hit_conn = read_cmd_i.addr == CONN_STATUS_ADDR;
  assign hit_dc = read_cmd_i.addr == DC_FLAGS_ADDR;
  assign read_mux = hit_conn ? conn_reg : (hit_dc ? dc_reg : '0);

  // connection word accumulator
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conn_reg <= CONN_STATUS_RESET;
    end else begin
      conn_reg <= conn_next;
    end
  end

  // dc flags sampled every cycle from the comparators, independent of the enables
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dc_reg <= DC_FLAGS_RESET;
    end else begin
      dc_reg <= pack_dc(overrange_cmp_i, underrange_cmp_i);
    end
  end

  // frame snapshot: only the connection word goes out with the frame
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_reg <= CONN_STATUS_RESET;
    end else if (frame_load_i) begin
      frame_reg <= conn_reg;
    end
  end

  // read answer one cycle after the command
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_data_reg <= '0;
      read_valid_reg <= 1'b0;
    end else begin
      read_valid_reg <= read_cmd_i.valid;
      if (read_cmd_i.valid) begin
        read_data_reg <= read_mux;
      end
    end
  end

  assign frame_status_o = frame_reg;
  assign read_data_o = read_data_reg;
  assign read_valid_o = read_valid_reg;

  // assertions
  AST_SINGLE_METHOD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && !ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_LA_BIT] == $past(dc_fault_i.la))
    else $error("status not from dc method");
  AST_AC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_RA_BIT] == $past(ac_fault_i.ra))
    else $error("status not from ac method");
  AST_DC_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (read_cmd_i.valid && hit_dc) |=> read_valid_o && read_data_o == $past(dc_reg))
    else $error("dc register read mismatch");
  AST_CE_DC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_load_i && !dc_detect_en_i) |=> !conn_reg[CONN_CE_BIT])
    else $error("common electrode status without dc");
  AST_STICKY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (conn_reg[COR_LL_BIT] && !frame_load_i) |=> conn_reg[COR_LL_BIT])
    else $error("sticky flag lost without frame load");
  AST_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_load_i && conn_event == '0) |=> conn_reg == '0 && frame_status_o == $past(conn_reg))
    else $error("frame load did not clear or snapshot");
  AST_OVER: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    overrange_cmp_i.ce |=> dc_reg[OVR_CE_BIT])
    else $error("overrange flag missing");
  AST_UNDER: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    underrange_cmp_i.ra |=> dc_reg[UND_RA_BIT])
    else $error("underrange flag missing");
  AST_CONN_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (read_cmd_i.valid && hit_conn) |=> read_valid_o && read_data_o == $past(conn_reg))
    else $error("status register read mismatch");
  AST_RESERVED: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (conn_reg[19:14] == '0) && (conn_reg[9:0] == '0) && (dc_reg[19:14] == '0) && (dc_reg[8:3] == '0)
      && (dc_reg[1:0] == '0))
    else $error("reserved bit set");

  // dc-only mode: every limb electrode bit mirrors the dc detector
  AST_DC_ONLY_B23: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && !ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_RLD_BIT] == $past(dc_fault_i.right_leg_drive_electrode))
    else $error("bit 23 not from dc method");
  AST_DC_ONLY_B21: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && !ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_LL_BIT] == $past(dc_fault_i.ll))
    else $error("bit 21 not from dc method");
  AST_DC_ONLY_B20: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && !ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_RA_BIT] == $past(dc_fault_i.ra))
    else $error("bit 20 not from dc method");

  // ac-only mode: the limb bits follow the ac detector alone
  AST_AC_SOLO_B23: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (ac_detect_en_i && !dc_detect_en_i && frame_load_i) |=> conn_reg[CONN_RLD_BIT] == $past(ac_fault_i.right_leg_drive_electrode))
    else $error("bit 23 not from ac method");
  AST_AC_SOLO_B22: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (ac_detect_en_i && !dc_detect_en_i && frame_load_i) |=> conn_reg[CONN_LA_BIT] == $past(ac_fault_i.la))
    else $error("bit 22 not from ac method");
  AST_AC_SOLO_B21: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (ac_detect_en_i && !dc_detect_en_i && frame_load_i) |=> conn_reg[CONN_LL_BIT] == $past(ac_fault_i.ll))
    else $error("bit 21 not from ac method");

  // both enabled: a dc-only fault on a limb would be a leak into the ac word
  AST_BOTH_B23: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_RLD_BIT] == $past(ac_fault_i.right_leg_drive_electrode))
    else $error("bit 23 not ac when both run");
  AST_BOTH_B22: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && ac_detect_en_i && frame_load_i) |=> conn_reg[CONN_LA_BIT] == $past(ac_fault_i.la))
    else $error("bit 22 not ac when both run");
  AST_BOTH_NO_DC_B21: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dc_detect_en_i && ac_detect_en_i && frame_load_i && !ac_fault_i.ll) |=> !conn_reg[CONN_LL_BIT])
    else $error("dc result leaked into bit 21");

  // common electrode follows dc whenever dc runs; ac has no converter input there
  AST_CE_FROM_DC: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_load_i && dc_detect_en_i) |=> conn_reg[CONN_CE_BIT] == $past(dc_fault_i.ce))
    else $error("common electrode status not from dc");

  // no method enabled: a fresh frame reports every electrode connected
  AST_NO_METHOD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_load_i && !dc_detect_en_i && !ac_detect_en_i) |=> (conn_reg[23:20] == '0) && !conn_reg[CONN_CE_BIT])
    else $error("disconnect reported with no method");

  // converter range flags land on their own bit and leave with the frame
  AST_COR_B12: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    conv_out_of_range_i.la |=> conn_reg[COR_LA_BIT])
    else $error("range flag bit 12 missing");
  AST_COR_B11: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    conv_out_of_range_i.ll |=> conn_reg[COR_LL_BIT])
    else $error("range flag bit 11 missing");
  AST_COR_B10: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    conv_out_of_range_i.ra |=> conn_reg[COR_RA_BIT])
    else $error("range flag bit 10 missing");
  AST_COR_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_load_i && !conv_out_of_range_i.la) |=> !conn_reg[COR_LA_BIT])
    else $error("range flag survived frame load");

  // frame hand-off: the snapshot is taken once per load and then holds
  AST_SNAPSHOT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    frame_load_i |=> frame_status_o == $past(conn_reg))
    else $error("frame snapshot mismatch");
  AST_STICKY_B20: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (conn_reg[CONN_RA_BIT] && !frame_load_i) |=> conn_reg[CONN_RA_BIT])
    else $error("bit 20 lost without frame load");
  AST_FRAME_HOLD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !frame_load_i |=> $stable(frame_status_o))
    else $error("frame snapshot moved without load");

  // overrange flags, one per electrode
  AST_OVER_B23: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    overrange_cmp_i.right_leg_drive_electrode |=> dc_reg[OVR_RLD_BIT])
    else $error("overrange bit 23 missing");
  AST_OVER_B22: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    overrange_cmp_i.la |=> dc_reg[OVR_LA_BIT])
    else $error("overrange bit 22 missing");
  AST_OVER_B21: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    overrange_cmp_i.ll |=> dc_reg[OVR_LL_BIT])
    else $error("overrange bit 21 missing");
  AST_OVER_B20: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    overrange_cmp_i.ra |=> dc_reg[OVR_RA_BIT])
    else $error("overrange bit 20 missing");

  // underrange flags, one per electrode
  AST_UNDER_B12: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    underrange_cmp_i.right_leg_drive_electrode |=> dc_reg[UND_RLD_BIT])
    else $error("underrange bit 12 missing");
  AST_UNDER_B11: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    underrange_cmp_i.la |=> dc_reg[UND_LA_BIT])
    else $error("underrange bit 11 missing");
  AST_UNDER_B10: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    underrange_cmp_i.ll |=> dc_reg[UND_LL_BIT])
    else $error("underrange bit 10 missing");
  AST_UNDER_B02: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    underrange_cmp_i.ce |=> dc_reg[UND_CE_BIT])
    else $error("underrange bit 2 missing");

  // comparators are levels, not latches: a dropped input clears its flag
  AST_OVER_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !overrange_cmp_i.la |=> !dc_reg[OVR_LA_BIT])
    else $error("overrange flag held after comparator dropped");
  AST_UNDER_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !underrange_cmp_i.ll |=> !dc_reg[UND_LL_BIT])
    else $error("underrange flag held after comparator dropped");

  // read port: unmapped places answer zero, and the answer holds between reads
  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (read_cmd_i.valid && !hit_conn && !hit_dc) |=> read_valid_o && (read_data_o == '0))
    else $error("unmapped read not zero");
  AST_NO_STRAY_VALID: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !read_cmd_i.valid |=> !read_valid_o)
    else $error("read answer without command");
  AST_READ_HOLD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !read_cmd_i.valid |=> $stable(read_data_o))
    else $error("read data moved without command");

  // reserved fields stay clear in every word the host can see
  AST_READ_RESERVED: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (read_data_o[19:14] == '0) && (read_data_o[1:0] == '0))
    else $error("reserved bit set in read answer");
  AST_FRAME_NO_DC: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (frame_status_o[19:14] == '0) && (frame_status_o[9:0] == '0))
    else $error("dc flag found in frame word");

  COV_BOTH_EN: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    dc_detect_en_i && ac_detect_en_i && ac_fault_i.la);
  COV_FRAME_LOAD: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    conn_reg != '0 ##1 frame_load_i);
  COV_DC_READ: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    read_cmd_i.valid && hit_dc && dc_reg != '0);
  COV_WRITE_IGNORED: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    write_cmd_i && read_cmd_i.valid);
  COV_UNMAPPED_READ: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    read_cmd_i.valid && !hit_conn && !hit_dc);

endmodule : electrode_fault_status
`default_nettype wire

// >>> testbench/status_host_model.sv
// host side model: issues register reads and stray writes on the command port
`timescale 1ns/1ps
`default_nettype none
module status_host_model
  import electrode_fault_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  output var read_cmd_type read_cmd_o,
  output logic write_cmd_o
);
  logic [7:0] pick;
  // one-cycle read pulses at random spacing, back to back included; some land on unmapped places
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_cmd_o <= '0;
      write_cmd_o <= 1'b0;
    end else begin
      pick = 8'($urandom);
      read_cmd_o.valid <= pick[0] | pick[1];
      read_cmd_o.addr <= pick[7] ? 8'($urandom) : (pick[2] ? CONN_STATUS_ADDR : DC_FLAGS_ADDR);
      write_cmd_o <= pick[3] & pick[4];
    end
  end
endmodule : status_host_model
`default_nettype wire

// >>> testbench/electrode_fault_status_tb.sv
// bench: random fault traffic and host reads checked against a reference model
`timescale 1ns/1ps
`default_nettype none
module electrode_fault_status_tb;
  import electrode_fault_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic dc_en = 1'b0, ac_en = 1'b0, frame_load = 1'b0, write_cmd, read_valid, pend, pend_ld;
  electrode_vec_type dc_f = '0, ac_f = '0, ovr = '0, und = '0;
  channel_vec_type cor = '0;
  read_cmd_type rd_cmd;
  logic [REG_W-1:0] frame_status, read_data, acc_m, dc_m, exp_d, exp_fs;
  int error_cnt = 0, comparisons = 0, cycles = 0;

  electrode_fault_status i_electrode_fault_status (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .dc_detect_en_i(dc_en), .ac_detect_en_i(ac_en), .dc_fault_i(dc_f), .ac_fault_i(ac_f),
    .conv_out_of_range_i(cor), .overrange_cmp_i(ovr), .underrange_cmp_i(und), .frame_load_i(frame_load),
    .read_cmd_i(rd_cmd), .write_cmd_i(write_cmd), .frame_status_o(frame_status),
    .read_data_o(read_data), .read_valid_o(read_valid));
  status_host_model i_status_host_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .read_cmd_o(rd_cmd), .write_cmd_o(write_cmd));

  // per-cycle events: ac wins when enabled, common electrode only ever from dc
  function automatic logic [REG_W-1:0] ev(input logic de, ae, input electrode_vec_type d, a,
                                           input channel_vec_type c);
    electrode_vec_type s;
    s = ae ? a : (de ? d : '0);
    ev = '0;
    ev[23:20] = {s.right_leg_drive_electrode, s.la, s.ll, s.ra};
    ev[13] = d.ce & de;
    ev[12:10] = c;
  endfunction : ev

  // dc word: overrange high group, underrange low group, reserved zero
  function automatic logic [REG_W-1:0] dcw(input electrode_vec_type o, u);
    dcw = '0;
    dcw[23:20] = o[4:1];
    dcw[13] = o.ce;
    dcw[12:9] = u[4:1];
    dcw[2] = u.ce;
  endfunction : dcw

  task automatic chk(input string what, input logic [REG_W-1:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // reference model; answers are due one edge after the taken read, from pre-update values
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_m = '0;
      dc_m = '0;
      pend = 1'b0;
      pend_ld = 1'b0;
    end else begin
      if (pend) chk("read_data", exp_d, read_data);
      chk("read_valid", REG_W'(pend), REG_W'(read_valid));
      if (pend_ld) chk("frame_status", exp_fs, frame_status);
      pend = rd_cmd.valid;
      exp_d = (rd_cmd.addr == CONN_STATUS_ADDR) ? acc_m : ((rd_cmd.addr == DC_FLAGS_ADDR) ? dc_m : '0);
      pend_ld = frame_load;
      exp_fs = acc_m;
      acc_m = (frame_load ? '0 : acc_m) | ev(dc_en, ac_en, dc_f, ac_f, cor);
      dc_m = dcw(ovr, und);
    end
  end

  // hang guard well above the planned 1600 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  // each enable combination in turn; back-to-back loads open every phase
  initial begin
    void'($urandom(20));
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 400; k++) begin
        @(posedge sys_clk_i);
        {ac_en, dc_en} <= 2'(m);
        dc_f <= 5'($urandom);
        ac_f <= 5'($urandom);
        ovr <= 5'($urandom);
        und <= 5'($urandom);
        cor <= ($urandom_range(3) == 0) ? 3'($urandom) : 3'h0;
        frame_load <= (k < 8) || ($urandom_range(15) == 0);
      end
    end
    repeat (3) @(posedge sys_clk_i);
    finish_test();
  end
endmodule : electrode_fault_status_tb
`default_nettype wire
